// ==== design/ctfh_frame_handler.sv ====
// frame parser and reply builder of the contactless tag
//
// What this block does
// (RQ1) frames start with zero preamble then two sync bytes
// (RQ2) byte after sync holds info field length, matching the frame
// (RQ3) frame ends with two-byte crc over the info field only
// (RQ4) polling is code 0x00, six bytes: selector, option, timeslot
// (RQ5) wildcard selector 0xFFFF answers whatever selector is configured
// (RQ6) only timeslot zero; option zero means no extra reply data
// (RQ7) polling reply code 0x01, length 0x12, identifier then timing
// (RQ8) timing descriptor default 0xFFFF000000FFFFFF
// (RQ9) non-polling frames carry eight-byte identifier after the code
// (RQ10) code 0x08 is block write; one block gives length 0x20
// (RQ11) reader sends service count then two-byte service ids, 0x0900 user
// (RQ12) reader sends block count then two-byte block list entries
// (RQ13) block list entry 0x8000 selects user block zero
// (RQ14) write reply code 0x09, length 0x0C, identifier, two zero statuses
// (RQ15) bit rates 212 and 424 kbps are left to the rf front end; no anti-collision
// (RQ16) write data follows block list, sixteen bytes per block
// (RQ17) bad crc or length frames are dropped silently
`timescale 1ns/100ps
module ctfh_frame_handler (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_valid,
    input  wire logic        rx_frame_end,
    input  wire logic        tx_ready,
    input  wire logic [15:0] configured_system_selector,
    output logic      [7:0]  tx_byte,
    output logic             tx_valid,
    output logic             tx_last,
    output logic             wr_strobe,
    output logic      [3:0]  wr_addr,
    output logic      [7:0]  wr_data,
    output logic             wr_commit,
    output logic             frame_drop
);
    // ****************************************
    // receive framing
    // ****************************************
    typedef enum logic [2:0] {RX_HUNT, RX_SYNC2, RX_LEN, RX_INFO, RX_CRC, RX_DONE} ctfh_rx_e;
    typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_BODY, TX_CRC} ctfh_tx_e;

    ctfh_rx_e    rx_state_q;
    logic [7:0]  rx_len_q;
    logic [7:0]  rx_cnt_q;
    logic [15:0] rx_crc_q;
    logic [15:0] rx_got_crc_q;
    logic [2:0]  pre_cnt_q;
    logic [7:0]  cmd_q;
    logic [63:0] id_q;
    logic [15:0] sel_q;
    logic [7:0]  opt_q;
    logic [7:0]  slot_q;
    logic [7:0]  svc_cnt_q;
    logic [15:0] svc_q;
    logic [7:0]  blk_cnt_q;
    logic [15:0] blk_q;
    logic        crc_idx_q;
    logic [7:0]  wcnt_q;
    logic [63:0] tag_identifier;
    logic [63:0] response_time_params;

    assign tag_identifier       = ctfh_pkg::TAG_ID_DEFAULT;
    assign response_time_params = ctfh_pkg::TIMING_DEFAULT;

    // crc-16 ccitt step over one byte, msb first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ ctfh_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_step

    // byte offsets of block count, block entry and data depend on service count
    logic [7:0] pos_blk_cnt;
    logic [7:0] pos_blk;
    logic [7:0] pos_data;
    assign pos_blk_cnt = 8'(ctfh_pkg::POS_SVC) + {svc_cnt_q[6:0], 1'b0};          // RQ11
    assign pos_blk     = pos_blk_cnt + 8'h01;                                       // RQ12
    assign pos_data    = pos_blk + {blk_cnt_q[6:0], 1'b0};                          // RQ16

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_state_q <= RX_HUNT;
            pre_cnt_q  <= 3'h0;
            rx_len_q   <= 8'h00;
            rx_cnt_q   <= 8'h00;
            rx_crc_q   <= 16'h0000;
            crc_idx_q  <= 1'b0;
        end else if (rx_frame_end && rx_state_q != RX_DONE) begin
            rx_state_q <= RX_HUNT;
            pre_cnt_q  <= 3'h0;
        end else if (rx_valid) begin
            case (rx_state_q)
                RX_HUNT: begin
                    if (rx_byte == ctfh_pkg::PREAMBLE_BYTE) begin
                        if (pre_cnt_q != 3'h7) pre_cnt_q <= pre_cnt_q + 3'h1;
                    end else if (rx_byte == ctfh_pkg::SYNC_HI &&
                                 pre_cnt_q >= 3'(ctfh_pkg::PREAMBLE_LEN)) begin
                        rx_state_q <= RX_SYNC2;                                     // RQ1
                    end else begin
                        pre_cnt_q <= 3'h0;
                    end
                end
                RX_SYNC2: begin
                    rx_state_q <= (rx_byte == ctfh_pkg::SYNC_LO) ? RX_LEN : RX_HUNT; // RQ1
                    pre_cnt_q  <= 3'h0;
                end
                RX_LEN: begin
                    rx_len_q   <= rx_byte;                                          // RQ2
                    rx_cnt_q   <= 8'h01;
                    rx_crc_q   <= crc_step(ctfh_pkg::CRC_INIT, rx_byte);           // RQ3
                    rx_state_q <= (rx_byte < 8'h02) ? RX_HUNT : RX_INFO;
                end
                RX_INFO: begin
                    rx_crc_q <= crc_step(rx_crc_q, rx_byte);                        // RQ3
                    rx_cnt_q <= rx_cnt_q + 8'h01;
                    if (rx_cnt_q + 8'h01 == rx_len_q) begin
                        rx_state_q <= RX_CRC;
                        crc_idx_q  <= 1'b0;
                    end
                end
                RX_CRC: begin
                    crc_idx_q <= 1'b1;
                    if (crc_idx_q) rx_state_q <= RX_DONE;
                end
                default: rx_state_q <= RX_HUNT;
            endcase
        end else if (rx_state_q == RX_DONE) begin
            rx_state_q <= RX_HUNT;
            pre_cnt_q  <= 3'h0;
        end
    end

    // ****************************************
    // field capture
    // ****************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmd_q        <= 8'h00;
            id_q         <= 64'h0000_0000_0000_0000;
            sel_q        <= 16'h0000;
            opt_q        <= 8'h00;
            slot_q       <= 8'h00;
            svc_cnt_q    <= 8'h00;
            svc_q        <= 16'h0000;
            blk_cnt_q    <= 8'h00;
            blk_q        <= 16'h0000;
            rx_got_crc_q <= 16'h0000;
        end else if (rx_valid && rx_state_q == RX_INFO) begin
            if (rx_cnt_q == 8'(ctfh_pkg::POS_CMD)) cmd_q <= rx_byte;
            if (cmd_q == ctfh_pkg::CMD_POLL) begin
                case (rx_cnt_q)                                                     // RQ4
                    8'h02:   sel_q  <= {rx_byte, sel_q[7:0]};
                    8'h03:   sel_q  <= {sel_q[15:8], rx_byte};
                    8'h04:   opt_q  <= rx_byte;
                    8'h05:   slot_q <= rx_byte;
                    default: ;
                endcase
            end
            if (rx_cnt_q >= 8'(ctfh_pkg::POS_ID) && rx_cnt_q < 8'(ctfh_pkg::POS_SVC_CNT))
                id_q <= {id_q[55:0], rx_byte};                                      // RQ9
            if (rx_cnt_q == 8'(ctfh_pkg::POS_SVC_CNT)) svc_cnt_q <= rx_byte;        // RQ11
            if (rx_cnt_q == 8'(ctfh_pkg::POS_SVC)) svc_q[15:8] <= rx_byte;
            if (rx_cnt_q == 8'(ctfh_pkg::POS_SVC) + 8'h01) svc_q[7:0] <= rx_byte;
            if (rx_cnt_q > 8'(ctfh_pkg::POS_SVC_CNT) && rx_cnt_q == pos_blk_cnt)
                blk_cnt_q <= rx_byte;                                               // RQ12
            if (rx_cnt_q > pos_blk_cnt && rx_cnt_q == pos_blk) blk_q[15:8] <= rx_byte;
            if (rx_cnt_q > pos_blk_cnt && rx_cnt_q == pos_blk + 8'h01) blk_q[7:0] <= rx_byte;
        end else if (rx_valid && rx_state_q == RX_CRC) begin
            rx_got_crc_q <= crc_idx_q ? {rx_got_crc_q[15:8], rx_byte}
                                      : {rx_byte, rx_got_crc_q[7:0]};
        end
    end

    // ****************************************
    // write data staging
    // ****************************************
    logic is_write;
    logic data_byte;
    assign is_write  = (cmd_q == ctfh_pkg::CMD_WRITE);                              // RQ10
    assign data_byte = rx_valid && rx_state_q == RX_INFO && is_write &&
                       rx_cnt_q > pos_blk && rx_cnt_q >= pos_data &&
                       wcnt_q < 8'(ctfh_pkg::BLOCK_BYTES);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_strobe <= 1'b0;
            wr_addr   <= 4'h0;
            wr_data   <= 8'h00;
            wcnt_q    <= 8'h00;
        end else begin
            wr_strobe <= data_byte;                                                 // RQ16
            if (data_byte) begin
                wr_addr <= wcnt_q[3:0];
                wr_data <= rx_byte;
                wcnt_q  <= wcnt_q + 8'h01;
            end
            if (rx_state_q == RX_LEN) wcnt_q <= 8'h00;
        end
    end

    // ****************************************
    // frame verdict
    // ****************************************
    logic frame_ok;
    logic poll_ok;
    logic write_ok;
    assign frame_ok = (rx_got_crc_q == rx_crc_q);                                   // RQ17
    assign poll_ok  = cmd_q == ctfh_pkg::CMD_POLL && rx_len_q == ctfh_pkg::LEN_POLL &&
                      (sel_q == ctfh_pkg::SELECTOR_ANY ||                           // RQ5
                       sel_q == configured_system_selector) &&
                      slot_q == ctfh_pkg::SLOT_ZERO;                                // RQ6 RQ15
    assign write_ok = is_write && id_q == tag_identifier && svc_cnt_q != 8'h00 &&
                      blk_cnt_q == 8'h01 && blk_q == ctfh_pkg::BLOCK_USER_ZERO &&  // RQ13
                      svc_q == ctfh_pkg::SERVICE_USER &&
                      rx_len_q == pos_data + 8'(ctfh_pkg::BLOCK_BYTES);             // RQ10

    // ****************************************
    // reply builder
    // ****************************************
    ctfh_tx_e    tx_state_q;
    logic [7:0]  tx_idx_q;
    logic [7:0]  tx_len_q;
    logic        tx_poll_q;
    logic [15:0] tx_crc_q;
    logic [7:0]  body_byte;
    logic [63:0] id_sh;
    logic [63:0] tm_sh;

    assign id_sh = tag_identifier << {tx_idx_q[2:0] - 3'h2, 3'h0};
    assign tm_sh = response_time_params << {tx_idx_q[2:0] - 3'h2, 3'h0};

    // info field byte at tx_idx_q; option byte is ignored, no extra data is sent
    always_comb begin
        body_byte = ctfh_pkg::STATUS_OK;                                            // RQ14
        if (tx_idx_q == 8'h00)
            body_byte = tx_len_q;                                                   // RQ2
        else if (tx_idx_q == 8'h01)
            body_byte = tx_poll_q ? ctfh_pkg::RSP_POLL : ctfh_pkg::RSP_WRITE;       // RQ7
        else if (tx_idx_q < 8'h0A)
            body_byte = id_sh[63:56];                                               // RQ9
        else if (tx_poll_q)
            body_byte = tm_sh[63:56];                                               // RQ8
    end

    logic accept_tx;
    assign accept_tx = !tx_valid || tx_ready;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_state_q <= TX_IDLE;
            tx_idx_q   <= 8'h00;
            tx_len_q   <= 8'h00;
            tx_poll_q  <= 1'b0;
            tx_crc_q   <= 16'h0000;
            tx_byte    <= 8'h00;
            tx_valid   <= 1'b0;
            tx_last    <= 1'b0;
            frame_drop <= 1'b0;
            wr_commit  <= 1'b0;
        end else begin
            frame_drop <= 1'b0;
            wr_commit  <= 1'b0;
            if (tx_valid && tx_ready) begin
                tx_valid <= 1'b0;
                tx_last  <= 1'b0;
            end
            case (tx_state_q)
                TX_IDLE: begin
                    if (rx_state_q == RX_DONE) begin
                        if (!frame_ok || !(poll_ok || write_ok)) begin
                            frame_drop <= 1'b1;                                     // RQ17
                        end else begin
                            tx_poll_q  <= poll_ok;
                            tx_len_q   <= poll_ok ? ctfh_pkg::LEN_POLL_RSP
                                                  : ctfh_pkg::LEN_WRITE_RSP;
                            wr_commit  <= write_ok;
                            tx_idx_q   <= 8'h00;
                            tx_state_q <= TX_PRE;
                        end
                    end
                end
                TX_PRE: if (accept_tx) begin                                        // RQ1
                    tx_valid <= 1'b1;
                    tx_idx_q <= tx_idx_q + 8'h01;
                    if (tx_idx_q < 8'(ctfh_pkg::PREAMBLE_LEN)) begin
                        tx_byte <= ctfh_pkg::PREAMBLE_BYTE;
                    end else if (tx_idx_q == 8'(ctfh_pkg::PREAMBLE_LEN)) begin
                        tx_byte <= ctfh_pkg::SYNC_HI;
                    end else begin
                        tx_byte    <= ctfh_pkg::SYNC_LO;
                        tx_idx_q   <= 8'h00;
                        tx_crc_q   <= ctfh_pkg::CRC_INIT;
                        tx_state_q <= TX_BODY;
                    end
                end
                TX_BODY: if (accept_tx) begin
                    tx_valid <= 1'b1;
                    tx_byte  <= body_byte;
                    tx_crc_q <= crc_step(tx_crc_q, body_byte);                      // RQ3
                    tx_idx_q <= tx_idx_q + 8'h01;
                    if (tx_idx_q + 8'h01 == tx_len_q) begin
                        tx_idx_q   <= 8'h00;
                        tx_state_q <= TX_CRC;
                    end
                end
                TX_CRC: if (accept_tx) begin
                    tx_valid <= 1'b1;
                    tx_byte  <= tx_idx_q[0] ? tx_crc_q[7:0] : tx_crc_q[15:8];       // RQ3
                    tx_idx_q <= tx_idx_q + 8'h01;
                    if (tx_idx_q[0]) begin
                        tx_last    <= 1'b1;
                        tx_state_q <= TX_IDLE;
                    end
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    // the bit-rate (RQ15) lives in the rf front end; this block works per byte
endmodule : ctfh_frame_handler

// ==== pkg/ctfh_pkg.sv ====
// constants for the contactless tag frame handler
package ctfh_pkg;
    // frame framing
    localparam logic [7:0]  PREAMBLE_BYTE    = 8'h00;
    localparam int          PREAMBLE_LEN     = 6;
    localparam logic [7:0]  SYNC_HI          = 8'hB2;
    localparam logic [7:0]  SYNC_LO          = 8'h4D;
    // command and response codes
    localparam logic [7:0]  CMD_POLL         = 8'h00;
    localparam logic [7:0]  RSP_POLL         = 8'h01;
    localparam logic [7:0]  CMD_WRITE        = 8'h08;
    localparam logic [7:0]  RSP_WRITE        = 8'h09;
    // information field lengths
    localparam logic [7:0]  LEN_POLL         = 8'h06;
    localparam logic [7:0]  LEN_POLL_RSP     = 8'h12;
    localparam logic [7:0]  LEN_WRITE_ONE    = 8'h20;
    localparam logic [7:0]  LEN_WRITE_RSP    = 8'h0C;
    // field values
    localparam logic [15:0] SELECTOR_ANY     = 16'hFFFF;
    localparam logic [7:0]  REQ_OPT_NONE     = 8'h00;
    localparam logic [7:0]  SLOT_ZERO        = 8'h00;
    localparam logic [15:0] SERVICE_USER     = 16'h0900;
    localparam logic [15:0] BLOCK_USER_ZERO  = 16'h8000;
    localparam logic [7:0]  STATUS_OK        = 8'h00;
    localparam logic [63:0] TIMING_DEFAULT   = 64'hFFFF_0000_00FF_FFFF;
    // arbitrary identifier value, not tied to any part
    localparam logic [63:0] TAG_ID_DEFAULT   = 64'h0123_4567_89AB_CDEF;
    localparam logic [15:0] SELECTOR_DEFAULT = 16'h0001;
    localparam logic [15:0] CRC_INIT         = 16'h0000;
    localparam logic [15:0] CRC_POLY         = 16'h1021;
    localparam int          BLOCK_BYTES      = 16;
    // byte positions inside the information field (after info_length)
    localparam int          POS_CMD          = 1;
    localparam int          POS_ID           = 2;
    localparam int          POS_SVC_CNT      = 10;
    localparam int          POS_SVC          = 11;
endpackage : ctfh_pkg

// ==== testbench/ctfh_frame_handler_sva.sv ====
// port checker for the frame handler
`timescale 1ns/100ps
module ctfh_frame_handler_sva (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       tx_ready,
    input wire logic [7:0] tx_byte,
    input wire logic       tx_valid,
    input wire logic       tx_last,
    input wire logic       wr_strobe,
    input wire logic [3:0] wr_addr,
    input wire logic       wr_commit,
    input wire logic       frame_drop
);
    // ****************************************
    // helper: address of the latest write byte
    // ****************************************
    logic [3:0] last_addr_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            last_addr_q <= 4'hF;
        end else if (wr_strobe) begin
            last_addr_q <= wr_addr;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("reply byte changed before it was taken");
    last_flag_a: assert property (tx_last |-> tx_valid)
        else $error("last flag without valid byte");
    tx_opens_a: assert property ($rose(tx_valid) |-> tx_byte == ctfh_pkg::PREAMBLE_BYTE)
        else $error("reply does not open with preamble");
    commit_pulse_a: assert property (wr_commit |=> !wr_commit)
        else $error("commit longer than one cycle");
    drop_pulse_a: assert property (frame_drop |=> !frame_drop)
        else $error("drop longer than one cycle");
    drop_no_commit_a: assert property (frame_drop |-> !wr_commit)
        else $error("drop and commit together");
    strobe_order_a: assert property (wr_strobe |-> wr_addr == last_addr_q + 4'h1)
        else $error("write byte out of order");
    commit_full_a: assert property (wr_commit |-> last_addr_q == 4'hF)
        else $error("commit before sixteen bytes");
    commit_reply_a: assert property (wr_commit |-> ##[1:4] tx_valid)
        else $error("no reply after commit");
    cover property (wr_commit);
    cover property (frame_drop);
    cover property (tx_last && tx_ready);
endmodule : ctfh_frame_handler_sva
bind ctfh_frame_handler ctfh_frame_handler_sva u_ctfh_frame_handler_sva (
    .core_clk(core_clk), .rst(rst), .tx_ready(tx_ready), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_last(tx_last), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
    .wr_commit(wr_commit), .frame_drop(frame_drop));

// ==== testbench/ctfh_reader_model.sv ====
// reader side model: sends frames, takes reply bytes with stalls
`timescale 1ns/100ps
module ctfh_reader_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_valid,
    input  wire logic       tx_last,
    output logic      [7:0] rx_byte,
    output logic            rx_valid,
    output logic            rx_frame_end,
    output logic            tx_ready
);
    // ****************************************
    // framing, crc and reply capture
    // ****************************************
    logic [7:0] got_q[$];
    int         last_idx = -1;
    int         stall = 0;
    int         seed = 32'h94331d2a;
    initial begin
        rx_byte = 8'h5A;
        rx_valid = 1'b0;
        rx_frame_end = 1'b0;
        tx_ready = 1'b0;
    end
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = ctfh_pkg::CRC_INIT;
        foreach (q[i]) begin
            c = c ^ {q[i], 8'h00};
            for (int b = 0; b < 8; b++) begin
                c = c[15] ? ((c << 1) ^ ctfh_pkg::CRC_POLY) : (c << 1);
            end
        end
        return c;
    endfunction : crc16
    function automatic void frame(input logic [7:0] inf[$], input logic [15:0] flip,
                                  output logic [7:0] f[$]);
        logic [15:0] c;
        c = crc16(inf) ^ flip;
        f = {};
        repeat (ctfh_pkg::PREAMBLE_LEN) f.push_back(ctfh_pkg::PREAMBLE_BYTE);
        f = {f, ctfh_pkg::SYNC_HI, ctfh_pkg::SYNC_LO, inf, c[15:8], c[7:0]};
    endfunction : frame
    task automatic send_frame(input logic [7:0] inf[$], input logic [15:0] flip, input int cut);
        logic [7:0] f[$];
        frame(inf, flip, f);
        if (cut > 0) f = f[0:cut-1];
        foreach (f[i]) begin
            @(posedge core_clk);
            #2;
            rx_byte = f[i];
            rx_valid = 1'b1;
        end
        @(posedge core_clk);
        #2;
        rx_valid = 1'b0;
        rx_byte = ~f[f.size()-1];
        rx_frame_end = (cut > 0);
        @(posedge core_clk);
        #2;
        rx_frame_end = 1'b0;
    endtask : send_frame
    always @(posedge core_clk) begin
        if (tx_valid && tx_ready) begin
            if (tx_last) last_idx = got_q.size();
            got_q.push_back(tx_byte);
        end
        tx_ready <= #2 (($random(seed) & 3) >= stall);
    end
endmodule : ctfh_reader_model

// ==== testbench/ctfh_frame_handler_test.sv ====
// self-checking bench of the frame handler
`timescale 1ns/100ps
module ctfh_frame_handler_test;
    // ****************************************
    // design, reader model and reference model
    // ****************************************
    typedef logic [7:0] ctfh_bq_t[$];
    logic core_clk = 0, rst = 1, rx_valid, rx_frame_end, tx_ready, tx_valid, tx_last;
    logic wr_strobe, wr_commit, frame_drop;
    logic [7:0] rx_byte, tx_byte, wr_data;
    logic [3:0] wr_addr;
    logic [15:0] cfg_sel = 16'h0001;
    logic [7:0] wr_q[$];
    int seed = 32'h94331d2a, checked = 0, miscompares = 0, commits, drops;
    ctfh_frame_handler u_ctfh_frame_handler (.core_clk(core_clk), .rst(rst),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_frame_end(rx_frame_end),
        .tx_ready(tx_ready), .configured_system_selector(cfg_sel), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_last(tx_last), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_commit(wr_commit), .frame_drop(frame_drop));
    ctfh_reader_model u_ctfh_reader_model (.core_clk(core_clk), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_last(tx_last), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .rx_frame_end(rx_frame_end), .tx_ready(tx_ready));
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic final_report;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    always @(posedge core_clk) begin
        if (!rst && wr_strobe !== 1'b0) begin
            check("write address", 16'(wr_q.size()), {12'h000, wr_addr});
            wr_q.push_back(wr_data);
        end
        commits += (wr_commit !== 1'b0);
        drops += (frame_drop !== 1'b0);
    end
    function automatic void put64(inout ctfh_bq_t q, input logic [63:0] v);
        for (int i = 7; i >= 0; i--) q.push_back(v[8*i+:8]);
    endfunction : put64
    function automatic int model(input ctfh_bq_t f, output ctfh_bq_t r);
        logic [63:0] id = 64'h0;
        r = {};
        if (f[0] != f.size()) return 0;
        if (f.size() == 6 && f[1] == ctfh_pkg::CMD_POLL && f[5] == ctfh_pkg::SLOT_ZERO
            && ({f[2], f[3]} == ctfh_pkg::SELECTOR_ANY || {f[2], f[3]} == cfg_sel)) begin
            r = {ctfh_pkg::LEN_POLL_RSP, ctfh_pkg::RSP_POLL};
            put64(r, ctfh_pkg::TAG_ID_DEFAULT);
            put64(r, ctfh_pkg::TIMING_DEFAULT);
            return 1;
        end
        if (f.size() != 32 || f[1] != ctfh_pkg::CMD_WRITE) return 0;
        for (int i = 2; i < 10; i++) id = {id[55:0], f[i]};
        if (id != ctfh_pkg::TAG_ID_DEFAULT || {f[14], f[15]} != ctfh_pkg::BLOCK_USER_ZERO)
            return 0;
        r = {ctfh_pkg::LEN_WRITE_RSP, ctfh_pkg::RSP_WRITE};
        put64(r, id);
        r = {r, ctfh_pkg::STATUS_OK, ctfh_pkg::STATUS_OK};
        return 2;
    endfunction : model
    function automatic ctfh_bq_t poll(input logic [15:0] sel, input logic [7:0] slot);
        return {ctfh_pkg::LEN_POLL, ctfh_pkg::CMD_POLL, sel[15:8], sel[7:0], 8'($random(seed)),
                slot};
    endfunction : poll
    function automatic ctfh_bq_t wrf(input logic [63:0] id, input logic [15:0] blk);
        ctfh_bq_t q = {ctfh_pkg::LEN_WRITE_ONE, ctfh_pkg::CMD_WRITE};
        put64(q, id);
        q = {q, 8'h01, ctfh_pkg::SERVICE_USER[15:8], ctfh_pkg::SERVICE_USER[7:0]};
        q = {q, 8'h01, blk[15:8], blk[7:0]};
        repeat (ctfh_pkg::BLOCK_BYTES) q.push_back(8'($random(seed)));
        return q;
    endfunction : wrf
    task automatic run(input ctfh_bq_t f, input logic [15:0] flip, input int cut);
        ctfh_bq_t r, e;
        int kind, n;
        kind = (flip == 16'h0 && cut == 0) ? model(f, r) : 0;
        u_ctfh_reader_model.got_q = {};
        u_ctfh_reader_model.last_idx = -1;
        wr_q = {};
        commits = 0;
        drops = 0;
        u_ctfh_reader_model.send_frame(f, flip, cut);
        for (n = 0; kind != 0 && u_ctfh_reader_model.last_idx < 0; n++) begin
            if (n == 3000) begin
                miscompares++;
                final_report();
            end
            @(posedge core_clk);
        end
        repeat (20) @(posedge core_clk);
        if (kind != 0) u_ctfh_reader_model.frame(r, 16'h0, e);
        check("reply size", 16'(e.size()), 16'(u_ctfh_reader_model.got_q.size()));
        foreach (e[i]) check("reply byte", 16'(e[i]), 16'(u_ctfh_reader_model.got_q[i]));
        if (kind != 0)
            check("last index", 16'(e.size() - 1), 16'(u_ctfh_reader_model.last_idx));
        check("drops", 16'(kind == 0 && cut == 0), 16'(drops));
        check("commits", 16'(kind == 2), 16'(commits));
        if (kind == 2) begin
            check("strobes", 16'(16), 16'(wr_q.size()));
            foreach (wr_q[i]) check("write data", 16'(f[16+i]), 16'(wr_q[i]));
        end
    endtask : run
    initial begin
        cfg_sel = 16'($random(seed)) | 16'h0100;
        repeat (2) @(posedge core_clk);
        #2 rst = 0;
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < 6; i++) begin
            u_ctfh_reader_model.stall = i % 4;
            run(poll((i == 0) ? ctfh_pkg::SELECTOR_ANY : (i < 3) ? cfg_sel : 16'($random(seed)),
                     (i == 2) ? 8'h01 : 8'h00), 16'h0, 0);
        end
        run(wrf(ctfh_pkg::TAG_ID_DEFAULT, ctfh_pkg::BLOCK_USER_ZERO), 16'h0, 0);
        run(wrf(ctfh_pkg::TAG_ID_DEFAULT, ctfh_pkg::BLOCK_USER_ZERO), 16'h0, 0);
        run(wrf(~ctfh_pkg::TAG_ID_DEFAULT, ctfh_pkg::BLOCK_USER_ZERO), 16'h0, 0);
        run(wrf(ctfh_pkg::TAG_ID_DEFAULT, 16'h8001), 16'h0, 0);
        run(wrf(ctfh_pkg::TAG_ID_DEFAULT, ctfh_pkg::BLOCK_USER_ZERO), 16'h0100, 0);
        run({8'h05, ctfh_pkg::CMD_POLL, 8'hFF, 8'hFF, 8'h00, 8'h00}, 16'h0, 0);
        run(poll(ctfh_pkg::SELECTOR_ANY, 8'h00), 16'h0, 11);
        run(poll(ctfh_pkg::SELECTOR_ANY, 8'h00), 16'h0, 0);
        final_report();
    end
endmodule : ctfh_frame_handler_test
